// File: core/pcs_buf2.v
// two-entry buffer with valid and ready on both sides
`timescale 1ns/10ps
module pcs_buf2 #(
   parameter WIDTH = 8
)(
   clk,
   resetn,
   in_data,
   in_valid,
   in_ready,
   out_data,
   out_valid,
   out_ready
);
   input wire clk;
   input wire resetn;
   input wire [WIDTH-1:0] in_data;
   input wire in_valid;
   output wire in_ready;
   output wire [WIDTH-1:0] out_data;
   output wire out_valid;
   input wire out_ready;
   reg [WIDTH-1:0] mem_ff [0:1];
   reg wp_ff;
   reg rp_ff;
   reg [1:0] cnt_ff;
   wire push;
   wire pop;
   assign in_ready = (cnt_ff != 2'h2);
   assign out_valid = (cnt_ff != 2'h0);
   assign out_data = mem_ff[rp_ff];
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;
   // pointer and count update
   always @(posedge clk)
   begin
      if (!resetn)
      begin
         wp_ff <= 1'b0;
         rp_ff <= 1'b0;
         cnt_ff <= 2'h0;
      end
      else
      begin
         if (push)
            wp_ff <= ~wp_ff;
         if (pop)
            rp_ff <= ~rp_ff;
         cnt_ff <= cnt_ff + {1'b0, push} - {1'b0, pop};
      end
   end
   // storage write
   always @(posedge clk)
   begin
      if (push)
         mem_ff[wp_ff] <= in_data;
   end
endmodule // pcs_buf2

// File: core/pcs_defs.vh
// timing, command and mode constants for the start-up sequencer
`ifndef PCS_DEFS_VH
`define PCS_DEFS_VH
`define PCS_CLK_MHZ 25
`define PCS_SUPPLY_WAIT_US 4500
`define PCS_WAKE_WAIT_US 30
`define PCS_PASSIVE_WAIT_US 32
`define PCS_CMD_WAKE 8'hAB
`define PCS_CMD_FAST_READ 8'h0B
`define PCS_START_ADDR 32'h00000000
`define PCS_DUMMY_CYCLES 6'h08
`define PCS_MODE_ACTIVE 1'b0
`define PCS_MODE_PASSIVE 1'b1
`define PCS_W1 3'h0
`define PCS_W2 3'h1
`define PCS_W4 3'h2
`define PCS_W8 3'h3
`define PCS_W16 3'h4
`define PCS_W32 3'h5
`endif

// File: core/pcs_sequencer.v
// start-up sequencer: reset wait, flash wake and fast read, bitstream load
`timescale 1ns/10ps
`include "pcs_defs.vh"
// How it works
// - loading waits 4.5 ms after supplies good and the mode delay after reset
// - active mode starts alone on the rising edge of config_reset_n
// - active mode drives the flash with instructions and address itself
// - first flash command is the release-from-power-down wake instruction
// - at least 30 us pass between wake and fast read
// - fast read starts at address zero, three or four address bytes
// - active clock comes from internal oscillator or the external clock pin
// - active widths 1,2,4,8; passive widths up to 32; bad width refused
// - 16 and 32 bit passive widths refused when security is enabled
// - device stays out of user mode until the memory is loaded
module pcs_sequencer #(
   parameter SUPPLY_WAIT_CYC = `PCS_SUPPLY_WAIT_US * `PCS_CLK_MHZ,
   parameter LOAD_BYTES = 16
)(
   clk,
   resetn,
   config_reset_n,
   mode_sel,
   width_sel,
   addr4_mode,
   security_en,
   clk_src_ext,
   external_config_clock_pin,
   flash_sck,
   flash_cs_n,
   flash_mosi,
   flash_miso,
   cfg_data,
   cfg_valid,
   cfg_ready,
   passive_ready,
   user_mode,
   width_error
);
   input wire clk;
   input wire resetn;
   input wire config_reset_n;
   input wire mode_sel;
   input wire [2:0] width_sel;
   input wire addr4_mode;
   input wire security_en;
   input wire clk_src_ext;
   input wire external_config_clock_pin;
   output reg flash_sck;
   output reg flash_cs_n;
   output reg flash_mosi;
   input wire flash_miso;
   output reg [7:0] cfg_data;
   output reg cfg_valid;
   input wire cfg_ready;
   output reg passive_ready;
   output reg user_mode;
   output reg width_error;

   localparam WAKE_CYC = `PCS_WAKE_WAIT_US * `PCS_CLK_MHZ;
   localparam PAS_CYC = `PCS_PASSIVE_WAIT_US * `PCS_CLK_MHZ;
   localparam [7:0] CMD_WAKE = `PCS_CMD_WAKE;
   localparam [31:0] START_ADDR = `PCS_START_ADDR;
   // read headers, command first, for three and four address bytes
   localparam [39:0] READ_HDR3 = {`PCS_CMD_FAST_READ, START_ADDR[23:0], 8'h00};
   localparam [39:0] READ_HDR4 = {`PCS_CMD_FAST_READ, START_ADDR};
   localparam S_RST = 3'h0, S_PWAIT = 3'h1, S_WAKE = 3'h2, S_WWAIT = 3'h3;
   localparam S_READ = 3'h4, S_LOAD = 3'h5, S_PASS = 3'h6, S_DONE = 3'h7;

   // width legality per mode and security
   function width_ok;
      input m;
      input [2:0] w;
      input sec;
      begin
         if (m == `PCS_MODE_ACTIVE)
            width_ok = (w <= `PCS_W8);
         else if (w >= `PCS_W16)
            width_ok = (w == `PCS_W16 || w == `PCS_W32) && !sec;
         else
            width_ok = 1'b1;
      end
   endfunction

   reg [2:0] rst_sync_ff;
   reg [2:0] ext_sync_ff;
   reg [1:0] miso_sync_ff;
   reg [2:0] state_ff;
   reg [23:0] cnt_ff;
   reg [5:0] bit_ff;
   reg [39:0] sh_ff;
   reg [7:0] rx_ff;
   reg [2:0] rxn_ff;
   reg [15:0] nbytes_ff;
   reg sup_ok_ff;
   reg tick;
   reg [7:0] b_data;
   reg b_valid;
   wire b_ready;
   wire [7:0] q_data;
   wire q_valid;
   wire rst_rise;
   wire reset_low;
   wire buf_resetn;

   // two-flop synchronisers, third stage only for edge detection
   always @(posedge clk)
   begin
      if (!resetn)
      begin
         rst_sync_ff <= 3'h0;
         ext_sync_ff <= 3'h0;
         miso_sync_ff <= 2'h0;
      end
      else
      begin
         rst_sync_ff <= {rst_sync_ff[1:0], config_reset_n};
         ext_sync_ff <= {ext_sync_ff[1:0], external_config_clock_pin};
         miso_sync_ff <= {miso_sync_ff[0], flash_miso};
      end
   end
   assign rst_rise = rst_sync_ff[1] && !rst_sync_ff[2];
   assign reset_low = !rst_sync_ff[1];
   // the buffer is flushed with the sequence so an abandoned load leaves no stale byte
   assign buf_resetn = resetn && !reset_low;

   // bit tick from the external pin's rising edge or every other cycle internally
   always @*
   begin
      if (clk_src_ext)
         tick = ext_sync_ff[1] && !ext_sync_ff[2];
      else
         tick = flash_sck;
   end

   // supply-good timer from device reset, ceiling counts on clk
   reg [23:0] sup_cnt_ff;
   always @(posedge clk)
   begin
      if (!resetn)
      begin
         sup_cnt_ff <= 24'h000000;
         sup_ok_ff <= 1'b0;
      end
      else if (sup_cnt_ff >= SUPPLY_WAIT_CYC[23:0] - 24'h000001)
         sup_ok_ff <= 1'b1;
      else
         sup_cnt_ff <= sup_cnt_ff + 24'h000001;
   end

   // main sequence
   always @(posedge clk)
   begin
      if (!resetn || reset_low)
      begin
         state_ff <= S_RST;
         cnt_ff <= 24'h000000;
         bit_ff <= 6'h00;
         sh_ff <= 40'h0000000000;
         rxn_ff <= 3'h0;
         rx_ff <= 8'h00;
         nbytes_ff <= 16'h0000;
         flash_sck <= 1'b0;
         flash_cs_n <= 1'b1;
         flash_mosi <= 1'b0;
         passive_ready <= 1'b0;
         user_mode <= 1'b0;
         width_error <= 1'b0;
         b_valid <= 1'b0;
         b_data <= 8'h00;
      end
      else
      begin
         // internal bit clock only; held low while the external pin clocks the flash
         flash_sck <= !clk_src_ext && (state_ff == S_WAKE || state_ff == S_READ || state_ff == S_LOAD) && !flash_sck;
         if (b_valid && b_ready)
            b_valid <= 1'b0;
         case (state_ff)
            S_RST:
               if (rst_rise)
               begin
                  if (!width_ok(mode_sel, width_sel, security_en))
                     width_error <= 1'b1;
                  else
                  begin
                     cnt_ff <= 24'h000000;
                     state_ff <= S_PWAIT;
                  end
               end
            S_PWAIT:
               if (sup_ok_ff)
               begin
                  if (mode_sel == `PCS_MODE_PASSIVE)
                     state_ff <= S_PASS;
                  else
                  begin
                     // first bit is set up before the first rising flash clock
                     flash_cs_n <= 1'b0;
                     flash_mosi <= CMD_WAKE[7];
                     sh_ff <= {CMD_WAKE[6:0], 33'h000000000};
                     bit_ff <= 6'h07;
                     state_ff <= S_WAKE;
                  end
               end
            S_WAKE:
               if (tick)
               begin
                  flash_mosi <= sh_ff[39];
                  sh_ff <= {sh_ff[38:0], 1'b0};
                  bit_ff <= bit_ff - 6'h01;
                  if (bit_ff == 6'h00)
                  begin
                     flash_cs_n <= 1'b1;
                     cnt_ff <= 24'h000000;
                     state_ff <= S_WWAIT;
                  end
               end
            S_WWAIT:
               if (cnt_ff >= WAKE_CYC[23:0])
               begin
                  // first header bit is set up before the first rising flash clock
                  flash_cs_n <= 1'b0;
                  flash_mosi <= addr4_mode ? READ_HDR4[39] : READ_HDR3[39];
                  sh_ff <= addr4_mode ? {READ_HDR4[38:0], 1'b0} : {READ_HDR3[38:0], 1'b0};
                  bit_ff <= addr4_mode ? 6'h28 + `PCS_DUMMY_CYCLES : 6'h20 + `PCS_DUMMY_CYCLES;
                  state_ff <= S_READ;
               end
               else
                  cnt_ff <= cnt_ff + 24'h000001;
            S_READ:
               if (tick)
               begin
                  flash_mosi <= sh_ff[39];
                  sh_ff <= {sh_ff[38:0], 1'b0};
                  bit_ff <= bit_ff - 6'h01;
                  // the external pin clocks the flash before its synchronised tick arrives, so the read ends one tick earlier
                  if (bit_ff == (clk_src_ext ? 6'h01 : 6'h00))
                     state_ff <= S_LOAD;
               end
            S_LOAD:
               if (tick && !b_valid)
               begin
                  rx_ff <= {rx_ff[6:0], miso_sync_ff[1]};
                  rxn_ff <= rxn_ff + 3'h1;
                  if (rxn_ff == 3'h7)
                  begin
                     b_data <= {rx_ff[6:0], miso_sync_ff[1]};
                     b_valid <= 1'b1;
                     nbytes_ff <= nbytes_ff + 16'h0001;
                     if (nbytes_ff == LOAD_BYTES[15:0] - 16'h0001)
                     begin
                        flash_cs_n <= 1'b1;
                        state_ff <= S_DONE;
                     end
                  end
               end
            S_PASS:
               if (cnt_ff >= PAS_CYC[23:0])
                  passive_ready <= 1'b1;
               else
                  cnt_ff <= cnt_ff + 24'h000001;
            S_DONE:
               if (!b_valid && !q_valid && !cfg_valid)
                  user_mode <= 1'b1;
            default:
               state_ff <= S_RST;
         endcase
      end
   end

   pcs_buf2 #(.WIDTH(8)) pcs_buf2_inst (
      .clk(clk),
      .resetn(buf_resetn),
      .in_data(b_data),
      .in_valid(b_valid),
      .in_ready(b_ready),
      .out_data(q_data),
      .out_valid(q_valid),
      .out_ready(cfg_ready || !cfg_valid)
   );

   // registered output stage toward the memory loader
   always @(posedge clk)
   begin
      if (!resetn || reset_low)
      begin
         cfg_valid <= 1'b0;
         cfg_data <= 8'h00;
      end
      else if (cfg_ready || !cfg_valid)
      begin
         cfg_valid <= q_valid;
         cfg_data <= q_data;
      end
   end
endmodule // pcs_sequencer

// File: verification/pcs_chk.sv
// concurrent checks on the start-up sequencer ports
`timescale 1ns/10ps
module pcs_chk #(
   parameter int SUPPLY_WAIT_CYC = 50
)(
   input wire clk,
   input wire resetn,
   input wire config_reset_n,
   input wire clk_src_ext,
   input wire flash_sck,
   input wire flash_cs_n,
   input wire [7:0] cfg_data,
   input wire cfg_valid,
   input wire cfg_ready,
   input wire passive_ready,
   input wire user_mode,
   input wire width_error
);
   localparam int WAKE_CYC = 750;
   logic [31:0] up_cnt_ff;
   logic [15:0] hi_cnt_ff;
   logic seen_ff;
   default clocking @(posedge clk); endclocking
   default disable iff (!resetn);
   // time since release, select-high run length, end of a frame seen
   always_ff @(posedge clk)
   begin
      if (!resetn)
      begin
         up_cnt_ff <= 32'h00000000;
         hi_cnt_ff <= 16'h0000;
         seen_ff <= 1'b0;
      end
      else
      begin
         if (up_cnt_ff < SUPPLY_WAIT_CYC) up_cnt_ff <= up_cnt_ff + 32'h00000001;
         hi_cnt_ff <= flash_cs_n ? hi_cnt_ff + 16'h0001 : 16'h0000;
         if (!config_reset_n) seen_ff <= 1'b0;
         else if ($rose(flash_cs_n)) seen_ff <= 1'b1;
      end
   end
   supply_wait_a: assert property (($fell(flash_cs_n) || $rose(passive_ready)) |-> up_cnt_ff >= SUPPLY_WAIT_CYC)
      else $error("load started before supply wait");
   wake_gap_a: assert property ($fell(flash_cs_n) && seen_ff |-> hi_cnt_ff >= WAKE_CYC)
      else $error("fast read too soon after wake");
   valid_hold_a: assert property (disable iff (!resetn || !config_reset_n)
      cfg_valid && !cfg_ready |=> cfg_valid && $stable(cfg_data)) else $error("offered byte dropped");
   abandon_load_a: assert property (!config_reset_n [*6] |-> flash_cs_n && !user_mode)
      else $error("load kept while reset pin low");
   user_gate_a: assert property ($rose(user_mode) |-> !cfg_valid && flash_cs_n)
      else $error("user mode before load drained");
   width_refuse_a: assert property (width_error |-> flash_cs_n && !cfg_valid && !user_mode && !passive_ready)
      else $error("refused width still loading");
   passive_quiet_a: assert property (passive_ready |-> flash_cs_n && !flash_sck)
      else $error("flash driven in passive mode");
   ext_clock_a: assert property (clk_src_ext && $past(clk_src_ext) |-> !flash_sck)
      else $error("internal clock on external source");
   cover property (cfg_valid && cfg_ready);
   cover property ($rose(user_mode));
   cover property ($rose(width_error));
   cover property ($rose(passive_ready));
endmodule // pcs_chk

// File: verification/pcs_flash_model.sv
// serial flash model answering the wake and fast read frames
`timescale 1ns/10ps
module pcs_flash_model (
   input wire sck,
   input wire cs_n,
   input wire mosi,
   input wire addr4,
   input wire arm,
   output logic miso,
   output logic [7:0] cmd0,
   output logic [7:0] cmd1,
   output logic addr_nz
);
   int bitn = 0;
   int frame = 0;
   int ab;
   int j;
   logic [7:0] sh;
   logic [7:0] dat;
   assign ab = addr4 ? 32 : 24;
   initial miso = 1'b0;
   // clear the log before each load
   always @(posedge arm)
   begin
      frame = 0;
      addr_nz = 1'b0;
      cmd0 = 8'h00;
      cmd1 = 8'h00;
   end
   // frame edges; a released line shows the inverse of its last value
   always @(negedge cs_n) bitn = 0;
   always @(posedge cs_n)
   begin
      frame = frame + 1;
      miso = ~miso;
   end
   // command and address shift in on rising sck
   always @(posedge sck) if (!cs_n)
   begin
      sh = {sh[6:0], mosi};
      bitn = bitn + 1;
      if (bitn == 8 && frame == 0) cmd0 = sh;
      if (bitn == 8 && frame > 0) cmd1 = sh;
      if (frame > 0 && bitn > 8 && bitn <= 8 + ab && mosi) addr_nz = 1'b1;
   end
   // data bytes msb first after the dummy bits, launched on falling sck
   always @(negedge sck) if (!cs_n && frame > 0 && bitn >= 16 + ab)
   begin
      j = bitn - 16 - ab;
      dat = 8'hC3 ^ j[10:3];
      miso = dat[7 - j[2:0]];
   end
endmodule // pcs_flash_model

// File: verification/powerup_config_start_sequencer_test.sv
// self-checking bench for the start-up sequencer
`timescale 1ns/10ps
`include "pcs_defs.vh"
module powerup_config_start_sequencer_test;
   logic clk = 1'b0;
   logic resetn = 1'b0;
   logic config_reset_n = 1'b0;
   logic mode_sel = 1'b0;
   logic [2:0] width_sel = 3'h0;
   logic addr4_mode = 1'b0;
   logic security_en = 1'b0;
   logic clk_src_ext = 1'b0;
   logic ext_pin;
   logic cfg_ready = 1'b0;
   logic slow = 1'b0;
   logic arm = 1'b0;
   logic [7:0] nb = 8'h00;
   logic [7:0] cyc = 8'h00;
   wire flash_miso, flash_sck, flash_cs_n, flash_mosi, cfg_valid, passive_ready, user_mode, width_error, addr_nz;
   wire [7:0] cfg_data, cmd0, cmd1;
   wire sck_m = clk_src_ext ? ext_pin : flash_sck;
   int n_fail = 0;
   int comparisons = 0;
   logic [5:0] wtab [0:4] = '{6'h3B, 6'h39, 6'h09, 6'h0D, 6'h36}; // mode, security, width, refused
   pcs_sequencer #(.SUPPLY_WAIT_CYC(50), .LOAD_BYTES(4)) pcs_sequencer_inst (.clk, .resetn, .config_reset_n,
      .mode_sel, .width_sel, .addr4_mode, .security_en, .clk_src_ext, .external_config_clock_pin(ext_pin),
      .flash_sck, .flash_cs_n, .flash_mosi, .flash_miso, .cfg_data, .cfg_valid, .cfg_ready, .passive_ready,
      .user_mode, .width_error);
   pcs_flash_model pcs_flash_model_inst (.sck(sck_m), .cs_n(flash_cs_n), .mosi(flash_mosi), .addr4(addr4_mode),
      .arm, .miso(flash_miso), .cmd0, .cmd1, .addr_nz);
   always #20 clk = ~clk;
   // external bit clock, free phase, still outside frames
   initial
   begin
      ext_pin = 1'b0;
      #3;
      forever #160 if (!flash_cs_n) ext_pin = ~ext_pin;
   end
   // loader side: a slow ready fills the buffer; each taken byte is checked
   always @(posedge clk)
   begin
      cyc <= cyc + 8'h01;
      cfg_ready <= !slow || cyc[4:0] == 5'h00;
      if (cfg_valid === 1'b1 && cfg_ready)
      begin
         chk("cfg_data", cfg_data, 8'hC3 ^ nb);
         nb <= nb + 8'h01;
      end
   end
   task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
      comparisons++;
      if (s !== e)
      begin
         n_fail++;
         $display("MISMATCH %s expected %0h seen %0h", nm, e, s);
      end
   endtask
   task results;
      $display("comparisons %0d mismatches %0d", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   task pin(input logic v);
      @(posedge clk);
      config_reset_n <= v;
   endtask
   task setup(input logic m, input logic [2:0] w, input logic s);
      pin(1'b0);
      repeat (8) @(posedge clk);
      mode_sel <= m;
      width_sel <= w;
      security_en <= s;
      arm <= 1'b1;
      nb <= 8'h00;
      pin(1'b1);
      arm <= 1'b0;
   endtask
   task t_active(input logic a4, input logic ex, input logic sl, input logic [2:0] w);
      int i;
      addr4_mode <= a4;
      clk_src_ext <= ex;
      slow <= sl;
      setup(1'b0, w, 1'b0);
      for (i = 0; i < 40000 && user_mode !== 1'b1; i++) @(posedge clk);
      chk("user_mode", user_mode, 1'b1);
      chk("wake", cmd0, `PCS_CMD_WAKE);
      chk("read", cmd1, `PCS_CMD_FAST_READ);
      chk("address", addr_nz, 1'b0);
      chk("bytes", nb, 8'h04);
      chk("width_error", width_error, 1'b0);
      if (i == 40000) results();
      $display("test active done");
   endtask
   task t_abort;
      int i;
      slow <= 1'b1;
      setup(1'b0, `PCS_W4, 1'b0);
      for (i = 0; i < 40000 && nb == 8'h00; i++) @(posedge clk);
      pin(1'b0);
      repeat (8) @(posedge clk);
      chk("abort cs_n", flash_cs_n, 1'b1);
      chk("abort valid", cfg_valid, 1'b0);
      chk("abort user", user_mode, 1'b0);
      if (i == 40000)
      begin
         n_fail++;
         results();
      end
      $display("test abort done");
   endtask
   task t_width;
      int k;
      for (k = 0; k < 5; k++)
      begin
         setup(wtab[k][5], wtab[k][3:1], wtab[k][4]);
         repeat (20) @(posedge clk);
         chk("width_error", width_error, wtab[k][0]);
      end
      $display("test width done");
   endtask
   task t_passive;
      int i;
      setup(1'b1, `PCS_W32, 1'b0);
      for (i = 0; i < 1000 && passive_ready !== 1'b1; i++) @(posedge clk);
      chk("early", i >= 800, 1'b1);
      chk("late", i <= 810, 1'b1);
      chk("flash idle", flash_cs_n, 1'b1);
      if (i == 1000) results();
      $display("test passive done");
   endtask
   // reset, then the scenarios in turn
   initial
   begin
      repeat (2) @(posedge clk);
      resetn <= 1'b1; // device reset released; the supply-good timer starts counting
      t_active(1'b0, 1'b0, 1'b1, `PCS_W1);
      t_abort;
      t_active(1'b1, 1'b1, 1'b0, `PCS_W8);
      t_active(1'b0, 1'b0, 1'b0, `PCS_W2);
      t_width;
      t_passive;
      results();
   end
endmodule // powerup_config_start_sequencer_test
bind pcs_sequencer pcs_chk #(.SUPPLY_WAIT_CYC(SUPPLY_WAIT_CYC)) pcs_chk_inst (.clk, .resetn, .config_reset_n,
   .clk_src_ext, .flash_sck, .flash_cs_n, .cfg_data, .cfg_valid, .cfg_ready, .passive_ready, .user_mode,
   .width_error);
